/* shared/rst_seq_pkg.sv */
// package for the reset sequencer: register map, bit positions, timing
// assumes a 32-bit APB slave with word-aligned registers
package rst_seq_pkg;
  localparam logic [7:0] CAUSE_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h08;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h0c;
  localparam logic [7:0] PC_ADDR = 8'h10;
  localparam int OVF_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam int WDT_BIT = 4;
  localparam int PIN_BIT = 3;
  localparam int RI_BIT = 2;
  localparam int POR_BIT = 1;
  localparam int BOR_BIT = 0;
  localparam int TO_BIT = 4;
  localparam int PD_BIT = 3;
  localparam logic [7:0] CAUSE_POR_VAL = 8'h1c;
  localparam logic [7:0] CAUSE_WMASK = 8'hdf;
  localparam logic [7:0] STATUS_POR_VAL = 8'h18;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] IRQ_VECTOR = 16'h0004;
  localparam int IRQ_W = 6;
  localparam int CLK_MHZ = 100;
  localparam int PWRT_US = 64;
  localparam int OST_US = 10;
  localparam int PWRT_CYC = PWRT_US * CLK_MHZ;
  localparam int OST_CYC = OST_US * CLK_MHZ;
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_RUN,
    ST_SLEEP
  } seq_state_type;
endpackage : rst_seq_pkg

/* src/rst_seq.sv */
// reset start-up sequencer and reset-cause flags with an APB slave
// assumes all inputs synchronous to clock_i; events are one-cycle pulses
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module rst_seq
  import rst_seq_pkg::*;
#(
  parameter int PWRT_CYCLES = PWRT_CYC,
  parameter int OST_CYCLES = OST_CYC
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic por_i,
  input wire logic bor_i,
  input wire logic external_reset_pin_i,
  input wire logic ext_reset_pin_enable_i,
  input wire logic low_voltage_program_mode_i,
  input wire logic powerup_timer_enable_n_i,
  input wire logic osc_needs_ost_i,
  input wire logic stack_reset_enable_i,
  input wire logic wdt_expire_i,
  input wire logic reset_instr_i,
  input wire logic stack_ovf_i,
  input wire logic stack_unf_i,
  input wire logic sleep_i,
  input wire logic irq_wake_i,
  input wire logic global_interrupt_enable_i,
  input wire logic [15:0] pc_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic core_run_o,
  output logic pc_load_o,
  output logic [15:0] pc_value_o,
  output logic push_return_o,
  output logic irq_o
);
  seq_state_type state_q;
  logic [31:0] pwrt_cnt_q;
  logic [31:0] ost_cnt_q;
  logic [7:0] cause_q;
  logic [7:0] status_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic asleep_q;
  logic vector_pend_q;
  logic pin_active;
  logic pin_rst;
  logic warm_rst;
  logic cold;
  logic wdt_rst;
  logic wdt_wake;
  logic stk_o;
  logic stk_u;
  logic ri_ev;
  logic timers_done;
  logic wr_en;
  logic rd_en;
  logic [IRQ_W-1:0] irq_ev;

  function automatic logic [31:0] dec_cnt(input logic [31:0] c);
    dec_cnt = (c == 32'h0) ? 32'h0 : c - 32'h1;
  endfunction : dec_cnt

  assign cold = por_i | bor_i | ~nrst_i;
  // pin counts only when its function is enabled or in low-voltage program mode
  assign pin_active = ext_reset_pin_enable_i | low_voltage_program_mode_i;
  assign pin_rst = pin_active & ~external_reset_pin_i;
  assign wdt_rst = wdt_expire_i & ~asleep_q & (state_q == ST_RUN);
  assign wdt_wake = wdt_expire_i & asleep_q;
  assign ri_ev = reset_instr_i & (state_q == ST_RUN);
  assign stk_o = stack_ovf_i & stack_reset_enable_i;
  assign stk_u = stack_unf_i & stack_reset_enable_i;
  // every warm source merges into one internal restart
  assign warm_rst = pin_rst | wdt_rst | ri_ev | stk_o | stk_u;
  assign timers_done = (pwrt_cnt_q == 32'h0) && (ost_cnt_q == 32'h0);
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_en = psel_i & penable_i & ~pwrite_i;
  assign irq_ev = {stk_o, stk_u, wdt_rst, pin_rst & ~asleep_q, ri_ev,
                   cold};

  // timers load on cold reset and ignore the pin
  always_ff @(posedge clock_i) begin
    if (por_i | bor_i | ~nrst_i) begin
      pwrt_cnt_q <= powerup_timer_enable_n_i ? 32'h0 : 32'(PWRT_CYCLES);
      ost_cnt_q <= osc_needs_ost_i ? 32'(OST_CYCLES) : 32'h0;
    end else begin
      pwrt_cnt_q <= dec_cnt(pwrt_cnt_q);
      ost_cnt_q <= dec_cnt(ost_cnt_q);
    end
  end

  always_ff @(posedge clock_i) begin
    if (cold) begin
      state_q <= ST_HOLD;
      asleep_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_HOLD: begin
          if (timers_done && !pin_rst) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (warm_rst) begin
            state_q <= ST_HOLD;
          end else if (sleep_i) begin
            state_q <= ST_SLEEP;
            asleep_q <= 1'b1;
          end
        end
        ST_SLEEP: begin
          if (pin_rst) begin
            state_q <= ST_HOLD;
            asleep_q <= 1'b0;
          end else if (wdt_wake || irq_wake_i) begin
            state_q <= ST_RUN;
            asleep_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // core control: run level, vector loads
  always_ff @(posedge clock_i) begin
    if (cold) begin
      core_run_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_value_o <= RESET_VECTOR;
      push_return_o <= 1'b0;
      vector_pend_q <= 1'b0;
    end else begin
      pc_load_o <= 1'b0;
      push_return_o <= 1'b0;
      core_run_o <= (state_q == ST_RUN) && !warm_rst && !sleep_i;
      if (state_q == ST_HOLD) begin
        pc_load_o <= 1'b1;
        pc_value_o <= RESET_VECTOR;
      end else if (state_q == ST_SLEEP && !pin_rst && irq_wake_i &&
                   !wdt_wake && global_interrupt_enable_i) begin
        vector_pend_q <= 1'b1;
      end else if (vector_pend_q) begin
        // one cycle after the wake, in the same cycle core_run_o rises; now take the vector
        vector_pend_q <= 1'b0;
        push_return_o <= 1'b1;
        pc_load_o <= 1'b1;
        pc_value_o <= IRQ_VECTOR;
      end
    end
  end

  // reset-cause flags; hardware events win over software writes
  always_ff @(posedge clock_i) begin
    if (por_i || !nrst_i) begin
      cause_q <= CAUSE_POR_VAL;
    end else if (bor_i) begin
      cause_q[OVF_BIT] <= 1'b0;
      cause_q[UNF_BIT] <= 1'b0;
      cause_q[WDT_BIT] <= 1'b1;
      cause_q[PIN_BIT] <= 1'b1;
      cause_q[RI_BIT] <= 1'b1;
      cause_q[BOR_BIT] <= 1'b0;
    end else begin
      if (wr_en && paddr_i == CAUSE_ADDR) begin
        // software may set or clear every bit but bit 5, power flags included
        cause_q <= pwdata_i[7:0] & CAUSE_WMASK;
      end
      if (wdt_rst) cause_q[WDT_BIT] <= 1'b0;
      if (pin_rst && state_q != ST_HOLD) cause_q[PIN_BIT] <= 1'b0;
      if (ri_ev) cause_q[RI_BIT] <= 1'b0;
      if (stk_o) cause_q[OVF_BIT] <= 1'b1;
      if (stk_u) cause_q[UNF_BIT] <= 1'b1;
    end
  end

  // core status: expiry and powerdown flags, active low
  always_ff @(posedge clock_i) begin
    if (cold) begin
      status_q <= STATUS_POR_VAL;
    end else if (wdt_rst) begin
      status_q[TO_BIT] <= 1'b0;
    end else if (state_q == ST_SLEEP && pin_rst) begin
      status_q[TO_BIT] <= 1'b1;
      status_q[PD_BIT] <= 1'b0;
    end else if (state_q == ST_SLEEP && wdt_wake) begin
      status_q[TO_BIT] <= 1'b0;
      status_q[PD_BIT] <= 1'b0;
    end else if (state_q == ST_SLEEP && irq_wake_i) begin
      status_q[TO_BIT] <= 1'b1;
      status_q[PD_BIT] <= 1'b0;
    end
  end

  // interrupt status: sticky, cleared by reading, set wins
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      if (rd_en && paddr_i == IRQ_STAT_ADDR) begin
        irq_stat_q <= irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      if (wr_en && paddr_i == IRQ_MASK_ADDR) begin
        irq_mask_q <= pwdata_i[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // apb: one-cycle access phase, unmapped reads zero with error
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
      if (psel_i && !penable_i) begin
        unique case (paddr_i)
          CAUSE_ADDR: prdata_o <= {24'h0, cause_q & CAUSE_WMASK};
          STATUS_ADDR: prdata_o <= {24'h0, status_q};
          IRQ_STAT_ADDR: prdata_o <= {26'h0, irq_stat_q};
          IRQ_MASK_ADDR: prdata_o <= {26'h0, irq_mask_q};
          PC_ADDR: prdata_o <= {16'h0, pc_i};
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end
endmodule : rst_seq

`default_nettype wire

/* testbench/rst_seq_properties.sv */
// checker for the reset sequencer ports
// bound onto every rst_seq instance; one clock domain
`timescale 1ns/10ps
`default_nettype none
module rst_seq_properties
  import rst_seq_pkg::*;
#(
  parameter int PWRT_CYCLES = PWRT_CYC
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic por_i,
  input wire logic bor_i,
  input wire logic external_reset_pin_i,
  input wire logic ext_reset_pin_enable_i,
  input wire logic powerup_timer_enable_n_i,
  input wire logic stack_reset_enable_i,
  input wire logic stack_ovf_i,
  input wire logic reset_instr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic core_run_o,
  input wire logic pc_load_o,
  input wire logic [15:0] pc_value_o,
  input wire logic push_return_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // cycles since the last cold release; a lower bound on any start
  int since_q;
  always_ff @(posedge clock_i) begin
    if (!nrst_i || por_i || bor_i) since_q <= 0;
    else since_q <= since_q + 1;
  end
  AST_PWRT: assert property ($rose(core_run_o) && !powerup_timer_enable_n_i
    |-> since_q >= PWRT_CYCLES) else $error("start before timer");
  AST_PIN_HOLD: assert property ((ext_reset_pin_enable_i
    && !external_reset_pin_i)[*4] |-> !core_run_o)
    else $error("runs with pin low");
  AST_LOAD_ZERO: assert property (pc_load_o && !push_return_o
    |-> pc_value_o == RESET_VECTOR) else $error("bad restart");
  AST_VECTOR: assert property (push_return_o |-> pc_load_o
    && pc_value_o == IRQ_VECTOR) else $error("bad vector");
  AST_READY: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready");
  AST_BIT5: assert property (pready_o && !pwrite_i && paddr_i == CAUSE_ADDR
    |-> prdata_o[5] == 1'b0 && prdata_o[31:8] == '0)
    else $error("bit five set");
  AST_UNMAP: assert property (pready_o && paddr_i > PC_ADDR
    |-> pslverr_o && prdata_o == '0) else $error("unmapped");
  AST_STK_OFF: assert property (!stack_reset_enable_i && stack_ovf_i
    && core_run_o |=> core_run_o[*3]) else $error("stack reset");
  AST_RI_LOAD: assert property (reset_instr_i && core_run_o
    && external_reset_pin_i |-> ##[1:8] pc_load_o)
    else $error("no restart");
endmodule : rst_seq_properties
bind rst_seq rst_seq_properties #(.PWRT_CYCLES(PWRT_CYCLES)) chk (.clock_i,
  .nrst_i, .por_i, .bor_i, .external_reset_pin_i, .ext_reset_pin_enable_i,
  .powerup_timer_enable_n_i, .stack_reset_enable_i, .stack_ovf_i,
  .reset_instr_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o,
  .pready_o, .pslverr_o, .core_run_o, .pc_load_o, .pc_value_o,
  .push_return_o);
`default_nettype wire

/* testbench/rst_src_model.sv */
// reset sources and core events facing the sequencer
// assumes requests held by the bench for the wanted length
`timescale 1ns/10ps
`default_nettype none
module rst_src_model (
  input wire logic clock_i,
  input wire logic [6:0] req_i,
  output logic [6:0] pulse_o,
  output logic pin_o
);
  // pin has a weak pull-up, so a released pin reads high
  always_ff @(posedge clock_i) begin
    pulse_o <= req_i & 7'h5f;
    pin_o <= !req_i[5];
  end
endmodule : rst_src_model
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the reset sequencer
// one 100 MHz clock; APB master and reset sources driven here
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import rst_seq_pkg::*;
;
  logic clock_i = 0, nrst = 0, por = 0, bor = 0, global_interrupt_enable = 0, stk = 0;
  logic psel = 0, penable = 0, pwrite = 0, err, pin, pen = 1, low_voltage_program_mode = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata_o;
  logic [6:0] req = '0, pulse;
  logic pready_o, pslverr_o, core_run_o, pc_load_o, push_return_o, irq_o;
  logic [15:0] pc_value_o;
  logic [6:0] evm [5] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h20};
  logic [31:0] want [5] = '{32'h1b, 32'h0b, 32'h8b, 32'hcb, 32'hc3};
  int miscompares = 0, cmp_count = 0, cyc = 0, pushes = 0;
  always #5 clock_i = !clock_i;
  rst_src_model src (.clock_i, .req_i(req), .pulse_o(pulse), .pin_o(pin));
  rst_seq #(.PWRT_CYCLES(4), .OST_CYCLES(2)) DUT (.clock_i, .nrst_i(nrst),
    .por_i(por), .bor_i(bor), .external_reset_pin_i(pin),
    .ext_reset_pin_enable_i(pen), .low_voltage_program_mode_i(low_voltage_program_mode),
    .powerup_timer_enable_n_i(1'b0), .osc_needs_ost_i(1'b1),
    .stack_reset_enable_i(stk), .wdt_expire_i(pulse[1]),
    .reset_instr_i(pulse[0]), .stack_ovf_i(pulse[2]), .stack_unf_i(pulse[3]),
    .sleep_i(pulse[6]), .irq_wake_i(pulse[4]), .global_interrupt_enable_i(global_interrupt_enable),
    .pc_i(16'h0123), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o, .pready_o, .pslverr_o,
    .core_run_o, .pc_load_o, .pc_value_o, .push_return_o, .irq_o);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a hung wait
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input int e, input string nm);
    apb(1'b0, a, 0);
    chk(nm, e, rd);
  endtask : rdc
  // bit 5 pin low, bit 6 sleep, others one-cycle events
  task automatic ev(input logic [6:0] m, input int len);
    req <= m;
    repeat (len) @(posedge clock_i);
    req <= '0;
    repeat (12) @(posedge clock_i);
  endtask : ev
  always @(posedge clock_i) begin
    cyc++;
    if (push_return_o === 1'b1) pushes++;
    if (cyc == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clock_i);
    nrst <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk("run_early", 0, core_run_o);
    repeat (8) @(posedge clock_i);
    chk("run", 1, core_run_o);
    rdc(CAUSE_ADDR, 32'h1c, "cause_por");
    rdc(STATUS_ADDR, 32'h18, "status_por");
    apb(1'b1, CAUSE_ADDR, 32'hff);
    rdc(CAUSE_ADDR, 32'hdf, "cause_sw");
    bor <= 1'b1;
    repeat (2) @(posedge clock_i);
    bor <= 1'b0;
    repeat (12) @(posedge clock_i);
    rdc(CAUSE_ADDR, 32'h1e, "cause_bor");
    req <= 7'h20;
    por <= 1'b1;
    repeat (2) @(posedge clock_i);
    por <= 1'b0;
    repeat (15) @(posedge clock_i);
    chk("pin_hold", 0, core_run_o);
    req <= '0;
    repeat (12) @(posedge clock_i);
    chk("pin_go", 1, core_run_o);
    pen <= 1'b0;
    ev(7'h20, 4);
    chk("pin_off_run", 1, core_run_o);
    low_voltage_program_mode <= 1'b1;
    ev(7'h20, 4);
    rdc(CAUSE_ADDR, 32'h14, "cause_pin_lvp");
    low_voltage_program_mode <= 1'b0;
    pen <= 1'b1;
    $display("test cold done");
    apb(1'b1, CAUSE_ADDR, 32'h1f);
    ev(7'h04, 1);
    rdc(CAUSE_ADDR, 32'h1f, "ovf_off");
    apb(1'b0, IRQ_STAT_ADDR, 0);
    apb(1'b1, IRQ_MASK_ADDR, 0);
    stk <= 1'b1;
    foreach (evm[i]) begin
      ev(evm[i], evm[i][5] ? 4 : 1);
      rdc(CAUSE_ADDR, want[i], "cause_warm");
    end
    rdc(STATUS_ADDR, 32'h08, "status_wdt");
    chk("irq_masked", 0, irq_o);
    apb(1'b1, IRQ_MASK_ADDR, 32'h3f);
    @(posedge clock_i);
    chk("irq_on", 1, irq_o);
    rdc(IRQ_STAT_ADDR, 32'h3e, "irq_stat");
    @(posedge clock_i);
    chk("irq_off", 0, irq_o);
    $display("test warm done");
    ev(7'h40, 1);
    ev(7'h02, 1);
    rdc(STATUS_ADDR, 32'h00, "status_wake");
    rdc(CAUSE_ADDR, 32'hc3, "cause_wake");
    ev(7'h40, 1);
    ev(7'h20, 4);
    rdc(STATUS_ADDR, 32'h10, "status_pin");
    global_interrupt_enable <= 1'b1;
    ev(7'h40, 1);
    ev(7'h10, 1);
    chk("push", 1, pushes);
    rdc(STATUS_ADDR, 32'h10, "status_irq");
    rdc(8'h40, 32'h0, "unmapped");
    chk("slverr", 1, err);
    $display("test sleep done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
